// *** pkg/vpc_pkg.sv ***
package vpc_pkg;
  localparam int NUM_SRC = 128;
  localparam int NUM_SW = 8;
  localparam int NUM_HW = NUM_SRC - NUM_SW;
  localparam int VEC_W = 9;
  localparam int PRI_W = 4;
  localparam int NUM_LVL = 16;
  localparam int SP_W = 5;
  localparam int IDX_W = 7;
  localparam logic [PRI_W-1:0] PRI_IDLE = 4'h0;
  localparam logic [SP_W-1:0] SP_EMPTY = 5'h00;
  localparam logic [SP_W-1:0] SP_FULL = 5'h10;
  localparam logic [SP_W-1:0] SP_ONE = 5'h01;
  localparam logic [2:0] SYNC_CLEAR = 3'h0;
  localparam int SYNC_MID = 1;
  localparam int SYNC_LAST = 2;
  localparam logic [NUM_SW-1:0] SW_CLEAR = 8'h00;
  localparam logic [VEC_W-1:0] VEC_NONE = 9'h000;

  typedef logic [PRI_W-1:0] pri_t;
  typedef logic [VEC_W-1:0] vec_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ = 2'b01
  } fwd_state_t;

  typedef struct packed {
    logic valid;
    vec_t vector;
    pri_t pri;
  } cand_t;

  typedef struct packed {
    logic set;
    pri_t value;
  } mask_wr_t;

  typedef struct packed {
    logic ack;
    logic end_service;
  } core_hs_t;
endpackage

// *** rtl/vpc_arbiter.sv ***
`timescale 1ns/10ps
module vpc_arbiter (
  input wire logic [vpc_pkg::NUM_SRC-1:0] pending_in,
  input wire logic [vpc_pkg::NUM_SRC*vpc_pkg::PRI_W-1:0] pri_in,
  output vpc_pkg::cand_t best_out
);
  import vpc_pkg::*;

  // Strict greater-than keeps the lowest index on a tie
  always_comb begin
    pri_t p;
    best_out = '{valid: 1'b0, vector: VEC_NONE, pri: PRI_IDLE};
    p = PRI_IDLE;
    for (int i = 0; i < NUM_SRC; i++) begin
      p = pri_in[i*PRI_W +: PRI_W];
      if (pending_in[i] && (!best_out.valid || p > best_out.pri)) begin
        best_out.valid = 1'b1;
        best_out.vector = VEC_W'(i);
        best_out.pri = p;
      end
    end
  end
endmodule

// *** rtl/vectored_priority_controller.sv ***
`timescale 1ns/10ps
// Function
// - Distinct 9-bit vector per each of 128 sources.
// - Per-source priority set by software.
// - Sixteen levels; ties broken by lowest index.
// - Forward only requests above current priority.
// - Software may raise and restore current priority.
// - Eight software set/clear interrupt sources.
// - Non-maskable request goes straight to critical.
module vectored_priority_controller (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [vpc_pkg::NUM_HW-1:0] hw_irq_in,
  input wire logic [vpc_pkg::NUM_SRC*vpc_pkg::PRI_W-1:0] src_pri_in,
  input wire logic [vpc_pkg::NUM_SW-1:0] sw_set_in,
  input wire logic [vpc_pkg::NUM_SW-1:0] sw_clear_in,
  input wire vpc_pkg::mask_wr_t mask_wr_in,
  input wire vpc_pkg::core_hs_t core_hs_in,
  input wire logic nmi_pin_in,
  output logic irq_req_out,
  output vpc_pkg::vec_t irq_vector_out,
  output vpc_pkg::pri_t irq_pri_out,
  output vpc_pkg::pri_t cur_pri_out,
  output logic [vpc_pkg::NUM_SW-1:0] sw_pending_out,
  output logic critical_irq_out
);
  import vpc_pkg::*;

  typedef logic [NUM_LVL-1:0][PRI_W-1:0] stack_t;

  typedef struct packed {
    fwd_state_t state;
    logic [NUM_SW-1:0] sw_req;
    pri_t cur_pri;
    stack_t stack;
    logic [SP_W-1:0] sp;
    logic irq;
    vec_t vector;
    pri_t pri;
    logic [2:0] nmi_sync;
    logic nmi;
  } state_t;

  // Stack contents are don't-care while the pointer is empty
  localparam state_t RESET_STATE = '{
    state: ST_IDLE,
    sw_req: SW_CLEAR,
    cur_pri: PRI_IDLE,
    stack: '0,
    sp: SP_EMPTY,
    irq: 1'b0,
    vector: VEC_NONE,
    pri: PRI_IDLE,
    nmi_sync: SYNC_CLEAR,
    nmi: 1'b0
  };

  state_t r;
  state_t next_r;
  cand_t best;
  pri_t src_pri [NUM_SRC];
  logic [NUM_SRC-1:0] raw_req;
  logic [NUM_SRC-1:0] enabled;
  logic [NUM_SRC-1:0] pending;
  logic [NUM_SW-1:0] sw_next;
  logic [SP_W-1:0] sp_up;
  logic [SP_W-1:0] sp_down;
  logic take;
  logic pop;
  logic nmi_settled;

  // True when level a may interrupt work running at level b
  function automatic logic outranks(input pri_t a, input pri_t b);
    return a > b;
  endfunction

  function automatic logic stack_empty(input logic [SP_W-1:0] sp);
    return sp == SP_EMPTY;
  endfunction

  // Full only after sixteen saves; the pointer never wraps
  function automatic logic stack_full(input logic [SP_W-1:0] sp);
    return sp == SP_FULL;
  endfunction

  // Slot of a pointer; its top bit only marks a full stack
  function automatic logic [SP_W-2:0] slot(input logic [SP_W-1:0] sp);
    return sp[SP_W-2:0];
  endfunction

  function automatic stack_t push_level(input stack_t stk,
    input logic [SP_W-1:0] sp,
    input pri_t level);
    stack_t out;
    out = stk;
    out[slot(sp)] = level;
    return out;
  endfunction

  function automatic pri_t saved_level(input stack_t stk,
    input logic [SP_W-1:0] sp);
    return stk[slot(sp - SP_ONE)];
  endfunction

  // A request stands only while it beats the running level
  function automatic logic forward(input cand_t c, input pri_t level,
    input logic ack);
    return c.valid && outranks(c.pri, level) && !ack;
  endfunction

  // Hardware lines are same-clock levels and need no synchroniser
  // Software sources take the lowest vectors so they win equal-level ties
  assign raw_req = {hw_irq_in, r.sw_req};

  // Set wins over a clear in the same cycle
  for (genvar s = 0; s < NUM_SW; s++) begin : g_sw
    assign sw_next[s] = sw_set_in[s] ||
      (r.sw_req[s] && !sw_clear_in[s]);
  end

  // Level zero parks a source without touching its request line
  for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
    assign src_pri[g] = src_pri_in[g*PRI_W +: PRI_W];
    assign enabled[g] = src_pri[g] != PRI_IDLE;
    assign pending[g] = raw_req[g] && enabled[g];
  end

  vpc_arbiter u_arb (
    .pending_in(pending),
    .pri_in(src_pri_in),
    .best_out(best)
  );

  // One adder each way keeps push and pop off a shared path
  assign sp_up = r.sp + SP_ONE;
  assign sp_down = r.sp - SP_ONE;

  // Ack while idle is dropped; the core only acks a standing request
  assign take = core_hs_in.ack && (r.state == ST_REQ);
  // Ack wins; an end of service in the same cycle is lost
  assign pop = core_hs_in.end_service && !take && !stack_empty(r.sp);
  // Three stages; a change counts once the last two agree
  assign nmi_settled = r.nmi_sync[SYNC_LAST] == r.nmi_sync[SYNC_MID];

  always_comb begin
    logic offer;
    next_r = r;
    offer = 1'b0;

    next_r.sw_req = sw_next;

    next_r.nmi_sync = {r.nmi_sync[SYNC_MID:0], nmi_pin_in};
    if (nmi_settled) begin
      next_r.nmi = r.nmi_sync[SYNC_LAST];
    end else begin
      next_r.nmi = r.nmi;
    end

    // Ceiling write; a same-cycle ack or end of service overrides it
    if (mask_wr_in.set) begin
      next_r.cur_pri = mask_wr_in.value;
    end

    if (take) begin
      // Full stack drops the save; the level is still raised
      if (!stack_full(r.sp)) begin
        next_r.stack = push_level(r.stack, r.sp, r.cur_pri);
        next_r.sp = sp_up;
      end
      next_r.cur_pri = r.pri;
    end else if (pop) begin
      next_r.sp = sp_down;
      next_r.cur_pri = saved_level(r.stack, r.sp);
    end

    // Ack withdraws the request; it is judged again against the new level
    offer = forward(best, next_r.cur_pri, core_hs_in.ack);

    // State only tracks whether a request stands
    case (r.state)
      ST_IDLE: begin
        if (offer) begin
          next_r.state = ST_REQ;
          next_r.vector = best.vector;
          next_r.pri = best.pri;
        end
      end
      ST_REQ: begin
        if (offer) begin
          // A higher arrival replaces the vector while the request stands
          next_r.vector = best.vector;
          next_r.pri = best.pri;
        end else begin
          next_r.state = ST_IDLE;
        end
      end
      default: begin
        next_r.state = ST_IDLE;
      end
    endcase

    next_r.irq = offer;
  end

  // Synchronous reset also empties the saved-level stack
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      r <= RESET_STATE;
    end else begin
      r <= next_r;
    end
  end

  // Every output is a field of the state register
  assign irq_req_out = r.irq;
  assign irq_vector_out = r.vector;
  assign irq_pri_out = r.pri;
  assign cur_pri_out = r.cur_pri;
  assign sw_pending_out = r.sw_req;
  assign critical_irq_out = r.nmi;
endmodule

// *** sim/vpc_asserts.sv ***
`timescale 1ns/10ps
module vpc_chk
  import vpc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] sw_set_in,
  input wire logic [7:0] sw_clear_in,
  input wire mask_wr_t mask_wr_in,
  input wire core_hs_t core_hs_in,
  input wire logic nmi_pin_in,
  input wire logic irq_req_out,
  input wire pri_t irq_pri_out,
  input wire pri_t cur_pri_out,
  input wire logic [7:0] sw_pending_out,
  input wire logic critical_irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  ack_raise_a: assert property (core_hs_in.ack && irq_req_out |=>
    cur_pri_out == $past(irq_pri_out)) else $error("ack level");
  mask_load_a: assert property (mask_wr_in.set && core_hs_in == 2'h0 |=>
    cur_pri_out == $past(mask_wr_in.value)) else $error("mask");
  mask_hold_a: assert property (!mask_wr_in.set && core_hs_in == 2'h0 |=>
    $stable(cur_pri_out)) else $error("level moved");
  req_above_a: assert property (irq_req_out |->
    irq_pri_out > cur_pri_out) else $error("not above");
  nmi_hi_a: assert property (nmi_pin_in [*6] |-> critical_irq_out)
    else $error("nmi high");
  nmi_lo_a: assert property (!nmi_pin_in [*6] |-> !critical_irq_out)
    else $error("nmi low");
  sw_set_a: assert property (sw_set_in != 8'h00 |=>
    (sw_pending_out & $past(sw_set_in)) == $past(sw_set_in)) else $error("set");
  sw_clr_a: assert property ((sw_clear_in & ~sw_set_in) != 8'h00 |=>
    (sw_pending_out & $past(sw_clear_in)) == 8'h00) else $error("clear");
  cover property (core_hs_in.end_service);
  cover property (critical_irq_out);
  cover property (mask_wr_in.set);
endmodule
bind vectored_priority_controller vpc_chk chk (.*);

// *** sim/vpc_core.sv ***
`timescale 1ns/10ps
module vpc_core (
  input wire logic clk_in,
  input wire logic en_in,
  input wire logic irq_req_in,
  output vpc_pkg::core_hs_t hs_out
);
  logic [3:0] cnt = 4'h0;
  // Busy core: no nested acks, so service runs four cycles
  always @(negedge clk_in) begin
    hs_out <= '{en_in && irq_req_in && cnt == 4'h0, cnt == 4'h1};
    if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
    else if (en_in && irq_req_in)
      cnt <= 4'h4;
  end
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  import vpc_pkg::*;
  logic clk_in = 1'h0, rst_b_in = 1'h0, nmi_pin_in = 1'h0, auto = 1'h0;
  logic [NUM_HW-1:0] hw_irq_in = '0;
  logic [511:0] src_pri_in = '0;
  logic [7:0] sw_set_in = '0, sw_clear_in = '0, sw_pending_out;
  mask_wr_t mask_wr_in = '0;
  core_hs_t hs = '0, mhs;
  wire core_hs_t core_hs_in = auto ? mhs : hs;
  logic irq_req_out, critical_irq_out;
  vec_t irq_vector_out;
  pri_t irq_pri_out, cur_pri_out;
  int mismatches = 0, comparisons = 0;
  logic [11:0] rows [3] = '{12'h10b, 12'hfff, 12'h8c0};
  vectored_priority_controller dut (.*);
  vpc_core core (.clk_in, .en_in(auto), .irq_req_in(irq_req_out),
    .hs_out(mhs));
  initial forever #50 clk_in = ~clk_in;
  task cyc(int n);
    repeat (n) @(negedge clk_in);
  endtask
  task chk(logic ok, string m);
    comparisons++;
    if (ok !== 1'h1) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task report_and_stop;
    $display("compares %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_in);
    mismatches++;
    report_and_stop();
  end
  initial begin
    cyc(10);
    rst_b_in = 1'h1;
    foreach (rows[i]) begin
      src_pri_in[rows[i][11:5]*4 +: 4] = rows[i][4:1];
      hw_irq_in[rows[i][11:5]-8] = 1'h1;
      cyc(2);
      chk(irq_req_out === rows[i][0], "req");
      chk(!rows[i][0] || irq_vector_out === rows[i][11:5], "vec");
      chk(!rows[i][0] || irq_pri_out === rows[i][4:1], "pri");
      hw_irq_in = '0;
      cyc(2);
    end
    $display("rows done");
    src_pri_in[83:80] = 4'h3;
    src_pri_in[43:40] = 4'h3;
    hw_irq_in[12] = 1'h1;
    hw_irq_in[2] = 1'h1;
    cyc(2);
    chk(irq_vector_out === 9'h00a, "tie");
    mask_wr_in = '{1'h1, 4'h3};
    cyc(1);
    mask_wr_in = '0;
    cyc(2);
    chk(!irq_req_out && cur_pri_out === 4'h3, "mask");
    src_pri_in[123:120] = 4'h9;
    hw_irq_in[22] = 1'h1;
    cyc(2);
    chk(irq_req_out && irq_vector_out === 9'h01e, "preempt");
    hs = 2'h2;
    cyc(1);
    chk(cur_pri_out === 4'h9, "ack");
    hs = 2'h1;
    cyc(1);
    hs = '0;
    cyc(1);
    chk(cur_pri_out === 4'h3 && irq_req_out, "pop");
    mask_wr_in = '{1'h1, 4'h0};
    hw_irq_in = '0;
    src_pri_in[11:8] = 4'hc;
    sw_set_in = 8'h04;
    cyc(1);
    mask_wr_in = '0;
    sw_set_in = '0;
    cyc(2);
    chk(irq_vector_out === 9'h002, "soft");
    auto <= 1'h1;
    cyc(2);
    chk(cur_pri_out === 4'hc, "core ack");
    cyc(4);
    chk(cur_pri_out === 4'h0, "core end");
    auto <= 1'h0;
    sw_clear_in = 8'h04;
    nmi_pin_in = 1'h1;
    cyc(6);
    chk(critical_irq_out && sw_pending_out === 8'h00, "nmi");
    rst_b_in = 1'h0;
    cyc(2);
    chk({irq_req_out, cur_pri_out, critical_irq_out} === 6'h00, "reset");
    $display("hand tests done");
    report_and_stop();
  end
endmodule
